// >>> common/counter_channel_pkg.sv
// Constants, types and register map for the counter channel
package counter_channel_pkg;

  // Register bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int DEB_W = 20;

  // Register byte offsets
  localparam logic [3:0] CONFIG_OFFSET = 4'h0;
  localparam logic [3:0] DEBOUNCE_OFFSET = 4'h4;
  localparam logic [3:0] RESULT_OFFSET = 4'h8;
  localparam logic [3:0] COUNT_OFFSET = 4'hc;

  // Mode codes in the config mode field
  localparam logic [2:0] MODE_CODE_COUNT = 3'h0;
  localparam logic [2:0] MODE_CODE_TOTALIZE = 3'h1;
  localparam logic [2:0] MODE_CODE_PERIOD = 3'h2;
  localparam logic [2:0] MODE_CODE_PULSE = 3'h3;
  localparam logic [2:0] MODE_CODE_TIMING = 3'h4;
  localparam logic [2:0] MODE_CODE_ENCODER = 3'h5;

  // Quadrature resolution codes
  localparam logic [1:0] QUAD_1X = 2'h0;
  localparam logic [1:0] QUAD_2X = 2'h1;
  localparam logic [1:0] QUAD_4X = 2'h2;

  // Config register layout, bit 0 upward is mode
  typedef struct packed {
    logic [18:0] rsvd;
    logic sec_rise;
    logic [1:0] quad_res;
    logic [1:0] intervals;
    logic [1:0] tick_sel;
    logic deb_after;
    logic edge_rise;
    logic wide;
    logic [2:0] mode;
  } cfg_s;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0010;
  localparam logic [DEB_W-1:0] DEBOUNCE_RESET = 20'h00000;

  // Clock and reference timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int REF_PERIOD_NS = 20;
  localparam logic [5:0] CLK_STEP = 6'(CLK_PERIOD_NS);
  localparam logic [5:0] REF_STEP = 6'(REF_PERIOD_NS);

  // Tick sizes in reference periods: 20 ns, 200 ns, 2 us, 20 us
  localparam logic [9:0] TICK_DIV_20NS = 10'd1;
  localparam logic [9:0] TICK_DIV_200NS = 10'd10;
  localparam logic [9:0] TICK_DIV_2US = 10'd100;
  localparam logic [9:0] TICK_DIV_20US = 10'd1000;

  // Periods per period measurement
  localparam logic [9:0] PERIODS_1 = 10'd1;
  localparam logic [9:0] PERIODS_10 = 10'd10;
  localparam logic [9:0] PERIODS_100 = 10'd100;
  localparam logic [9:0] PERIODS_1000 = 10'd1000;

  // Counter ceilings
  localparam logic [31:0] MAX_NARROW = 32'h0000_ffff;
  localparam logic [31:0] MAX_WIDE = 32'hffff_ffff;

  // Channel positions that may decode quadrature
  localparam int QUAD_FIRST_CH = 0;
  localparam int QUAD_FIFTH_CH = 4;

  typedef enum logic [2:0] {
    MODE_COUNT,
    MODE_TOTALIZE,
    MODE_PERIOD,
    MODE_PULSE,
    MODE_TIMING,
    MODE_ENCODER
  } mode_e;

  // Per-scan answer to the main unit
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } scan_s;

endpackage

// >>> design/multimode_counter_channel.sv
// One multimode counter/timer channel with its register port
`timescale 1ns/1ps
module multimode_counter_channel
  import counter_channel_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic main_in,
  input wire logic phase_b_in,
  input wire logic index_in,
  input wire logic second_in,
  input wire logic scan_strobe,
  output scan_s scan_out
);

  localparam bit QUAD_OK = (CHANNEL_INDEX == QUAD_FIRST_CH) || (CHANNEL_INDEX == QUAD_FIFTH_CH);

  function automatic mode_e decode_mode(input logic [2:0] code);
    mode_e m;
    m = MODE_COUNT;
    unique case (code)
      MODE_CODE_COUNT: m = MODE_COUNT;
      MODE_CODE_TOTALIZE: m = MODE_TOTALIZE;
      MODE_CODE_PERIOD: m = MODE_PERIOD;
      MODE_CODE_PULSE: m = MODE_PULSE;
      MODE_CODE_TIMING: m = MODE_TIMING;
      MODE_CODE_ENCODER: m = QUAD_OK ? MODE_ENCODER : MODE_COUNT;
      default: m = MODE_COUNT;
    endcase
    return m;
  endfunction

  function automatic logic [9:0] decade(input logic [1:0] sel, input logic [9:0] v1,
                                        input logic [9:0] v10, input logic [9:0] v100,
                                        input logic [9:0] v1000);
    logic [9:0] r;
    r = v1;
    unique case (sel)
      2'h0: r = v1;
      2'h1: r = v10;
      2'h2: r = v100;
      2'h3: r = v1000;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] sat_add(input logic [31:0] v, input logic [1:0] inc,
                                          input logic [31:0] lim);
    logic [32:0] s;
    s = {1'b0, v} + {31'h0, inc};
    return (s > {1'b0, lim}) ? lim : s[31:0];
  endfunction

  // Registers
  cfg_s cfg_reg;
  logic [DEB_W-1:0] deb_time_reg;
  logic cfg_wr;
  mode_e mode;
  logic [31:0] cnt_max;

  assign cfg_wr = reg_wr && (reg_addr == CONFIG_OFFSET);
  assign mode = decode_mode(cfg_reg.mode);
  assign cnt_max = cfg_reg.wide ? MAX_WIDE : MAX_NARROW;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_reg <= cfg_s'(CONFIG_RESET);
      deb_time_reg <= DEBOUNCE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CONFIG_OFFSET) begin
        cfg_reg <= cfg_s'(reg_wdata);
        cfg_reg.rsvd <= '0;
      end
      if (reg_addr == DEBOUNCE_OFFSET) begin
        deb_time_reg <= reg_wdata[DEB_W-1:0];
      end
    end
  end

  // Debounce of the main input
  logic [DEB_W-1:0] quiet_cnt_reg;
  logic raw_prev_reg, settled_reg, deb_out_reg, deb_prev_reg, stable;

  assign stable = (main_in == raw_prev_reg) && (quiet_cnt_reg == deb_time_reg);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw_prev_reg <= 1'b0;
      quiet_cnt_reg <= '0;
    end else begin
      raw_prev_reg <= main_in;
      if (main_in != raw_prev_reg) begin
        quiet_cnt_reg <= '0;
      end else if (quiet_cnt_reg != deb_time_reg) begin
        quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      deb_out_reg <= 1'b0;
      settled_reg <= 1'b1;
    end else if (cfg_reg.deb_after) begin
      settled_reg <= 1'b1;
      if (main_in != deb_out_reg && stable) begin
        deb_out_reg <= main_in;
      end
    end else if (main_in != deb_out_reg && settled_reg) begin
      deb_out_reg <= main_in;
      settled_reg <= 1'b0;
    end else if (stable) begin
      settled_reg <= 1'b1;
    end
  end

  // Edge detection
  // Second input delayed once so both edges see the same latency
  logic sec_dly_reg, sec_prev_reg, rise, fall, qual_edge, opp_edge, sec_edge;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      deb_prev_reg <= 1'b0;
      sec_dly_reg <= 1'b0;
      sec_prev_reg <= 1'b0;
    end else begin
      deb_prev_reg <= deb_out_reg;
      sec_dly_reg <= second_in;
      sec_prev_reg <= sec_dly_reg;
    end
  end

  assign rise = deb_out_reg && !deb_prev_reg;
  assign fall = !deb_out_reg && deb_prev_reg;
  assign qual_edge = cfg_reg.edge_rise ? rise : fall;
  assign opp_edge = cfg_reg.edge_rise ? fall : rise;
  assign sec_edge = cfg_reg.sec_rise ? (sec_dly_reg && !sec_prev_reg) :
                                       (!sec_dly_reg && sec_prev_reg);

  // Reference time base: 20 ns units gained per 25 ns clock
  logic [4:0] ref_acc_reg;
  logic [5:0] ref_sum;
  logic [9:0] pre_reg, tick_div;
  logic [10:0] pre_sum;
  logic [1:0] units, tick_inc;

  always_comb begin
    ref_sum = {1'b0, ref_acc_reg} + CLK_STEP;
    units = (ref_sum >= (REF_STEP << 1)) ? 2'd2 : 2'd1;
    tick_div = decade(cfg_reg.tick_sel, TICK_DIV_20NS, TICK_DIV_200NS,
                      TICK_DIV_2US, TICK_DIV_20US);
    pre_sum = {1'b0, pre_reg} + {9'h0, units};
    if (tick_div == TICK_DIV_20NS) begin
      tick_inc = units;
    end else begin
      tick_inc = (pre_sum >= {1'b0, tick_div}) ? 2'd1 : 2'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_acc_reg <= '0;
    end else if (units == 2'd2) begin
      ref_acc_reg <= 5'(ref_sum - (REF_STEP << 1));
    end else begin
      ref_acc_reg <= 5'(ref_sum - REF_STEP);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || cfg_wr) begin
      pre_reg <= '0;
    end else if (tick_div == TICK_DIV_20NS) begin
      pre_reg <= '0;
    end else if (pre_sum >= {1'b0, tick_div}) begin
      pre_reg <= 10'(pre_sum - {1'b0, tick_div});
    end else begin
      pre_reg <= pre_sum[9:0];
    end
  end

  // Quadrature decoding from raw phase inputs
  logic a_prev_reg, b_prev_reg, z_prev_reg, a_chg, b_chg, quad_step, quad_up;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      z_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= main_in;
      b_prev_reg <= phase_b_in;
      z_prev_reg <= index_in;
    end
  end

  assign a_chg = main_in != a_prev_reg;
  assign b_chg = phase_b_in != b_prev_reg;

  always_comb begin
    quad_step = 1'b0;
    quad_up = 1'b0;
    unique case (cfg_reg.quad_res)
      QUAD_1X: begin
        quad_step = main_in && !a_prev_reg && !b_chg;
        quad_up = !phase_b_in;
      end
      QUAD_2X: begin
        quad_step = a_chg && !b_chg;
        quad_up = main_in != phase_b_in;
      end
      default: begin
        quad_step = a_chg ^ b_chg;
        quad_up = a_chg ? (main_in != phase_b_in) : (main_in == phase_b_in);
      end
    endcase
  end

  // Measurement core
  logic [31:0] cnt_reg, result_reg, time_next, wrap_inc;
  logic running_reg;
  logic [9:0] per_n_reg, per_target;

  assign per_target = decade(cfg_reg.intervals, PERIODS_1, PERIODS_10,
                             PERIODS_100, PERIODS_1000);
  assign time_next = sat_add(cnt_reg, tick_inc, cnt_max);
  assign wrap_inc = (cnt_reg + 32'h1) & cnt_max;

  always_ff @(posedge clk) begin
    if (!rst_b || cfg_wr) begin
      cnt_reg <= '0;
      result_reg <= '0;
      running_reg <= 1'b0;
      per_n_reg <= '0;
    end else begin
      unique case (mode)
        MODE_COUNT: begin
          if (scan_strobe) begin
            result_reg <= cnt_reg;
            cnt_reg <= qual_edge ? 32'h1 : 32'h0;
          end else if (qual_edge) begin
            cnt_reg <= wrap_inc;
          end
        end
        MODE_TOTALIZE: begin
          if (qual_edge) begin
            cnt_reg <= wrap_inc;
          end
          result_reg <= cnt_reg;
        end
        MODE_PERIOD: begin
          if (qual_edge && !running_reg) begin
            running_reg <= 1'b1;
            cnt_reg <= '0;
            per_n_reg <= '0;
          end else if (qual_edge && (per_n_reg + 10'd1 == per_target)) begin
            result_reg <= time_next;
            cnt_reg <= '0;
            per_n_reg <= '0;
          end else begin
            if (qual_edge) begin
              per_n_reg <= per_n_reg + 10'd1;
            end
            if (running_reg) begin
              cnt_reg <= time_next;
            end
          end
        end
        MODE_PULSE: begin
          if (qual_edge) begin
            running_reg <= 1'b1;
            cnt_reg <= '0;
          end else if (opp_edge && running_reg) begin
            result_reg <= time_next;
            cnt_reg <= '0;
          end else if (running_reg) begin
            cnt_reg <= time_next;
          end
        end
        MODE_TIMING: begin
          if (sec_edge && running_reg) begin
            result_reg <= time_next;
            cnt_reg <= '0;
            running_reg <= 1'b0;
          end else if (qual_edge && !running_reg) begin
            running_reg <= 1'b1;
            cnt_reg <= '0;
          end else if (running_reg) begin
            cnt_reg <= time_next;
          end
        end
        MODE_ENCODER: begin
          if (index_in && !z_prev_reg) begin
            cnt_reg <= '0;
          end else if (quad_step) begin
            cnt_reg <= (quad_up ? cnt_reg + 32'h1 : cnt_reg - 32'h1) & cnt_max;
          end
          result_reg <= cnt_reg;
        end
      endcase
    end
  end

  // Scan answer: count held just before clearing in count mode, live count in totalize and encoder, else latest result
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scan_out <= '0;
    end else begin
      scan_out.valid <= scan_strobe;
      if (scan_strobe) begin
        if (mode == MODE_COUNT || mode == MODE_TOTALIZE || mode == MODE_ENCODER) begin
          scan_out.data <= cnt_reg;
        end else begin
          scan_out.data <= result_reg;
        end
      end
    end
  end

  // Register read port, data in the following cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CONFIG_OFFSET: reg_rdata <= 32'(cfg_reg);
        DEBOUNCE_OFFSET: reg_rdata <= {12'h000, deb_time_reg};
        RESULT_OFFSET: reg_rdata <= result_reg;
        COUNT_OFFSET: reg_rdata <= cnt_reg;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // multimode_counter_channel

// >>> tb/counter_channel_assertions.sv
// Port assertions for the counter channel
`timescale 1ns/1ps
module counter_channel_checker
  import counter_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic main_in,
  input wire logic scan_strobe,
  input wire scan_s scan_out
);
  logic [31:0] cfg;
  logic [19:0] deb;
  logic [5:0] quiet;
  logic last_main;
  logic calm;
  logic timed;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg <= CONFIG_RESET;
      deb <= 20'h0;
    end else if (reg_wr && reg_addr == CONFIG_OFFSET) begin
      cfg <= reg_wdata;
    end else if (reg_wr && reg_addr == DEBOUNCE_OFFSET) begin
      deb <= reg_wdata[19:0];
    end
  end

  // Cycles with no input change and no config write
  always_ff @(posedge clk) begin
    last_main <= main_in;
    if (!rst_b || main_in != last_main || (reg_wr && reg_addr == CONFIG_OFFSET)) begin
      quiet <= 6'h0;
    end else if (quiet != 6'h3f) begin
      quiet <= quiet + 6'h1;
    end
  end

  assign calm = quiet == 6'h3f && deb < 20'd40;
  assign timed = cfg[2:0] == MODE_CODE_PERIOD || cfg[2:0] == MODE_CODE_PULSE;

  a_scan_answer: assert property (scan_strobe |=> scan_out.valid)
    else $error("scan strobe got no answer");
  a_valid_single: assert property (!scan_strobe |=> !scan_out.valid)
    else $error("scan answer without strobe");
  a_data_hold: assert property (!scan_strobe |=> $stable(scan_out.data))
    else $error("scan data moved between scans");
  a_narrow_limit: assert property (
    scan_out.valid && !cfg[3] && $stable(cfg) |-> scan_out.data <= MAX_NARROW)
    else $error("narrow scan value above ceiling");
  a_count_narrow: assert property (
    reg_rd && reg_addr == COUNT_OFFSET && !cfg[3] |=> reg_rdata <= MAX_NARROW)
    else $error("narrow counter above ceiling");
  a_count_clear: assert property (
    cfg[2:0] == MODE_CODE_COUNT && calm && scan_strobe && $past(scan_strobe)
    |=> scan_out.data == 32'h0)
    else $error("event count not cleared by scan");
  a_latch_repeat: assert property (
    timed && calm && scan_strobe && $past(scan_strobe)
    |=> scan_out.data == $past(scan_out.data))
    else $error("latched result changed without input");
  a_cfg_readback: assert property (
    reg_rd && reg_addr == CONFIG_OFFSET |=> reg_rdata == {19'h0, cfg[12:0]})
    else $error("config readback wrong");

  cover property (scan_strobe && cfg[2:0] == MODE_CODE_PERIOD);
  cover property (scan_strobe && cfg[2:0] == MODE_CODE_PULSE);
  cover property (scan_strobe && cfg[2:0] == MODE_CODE_TIMING);
  cover property (scan_strobe [*2]);
endmodule // counter_channel_checker

bind multimode_counter_channel counter_channel_checker i_counter_channel_checker (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_in(main_in),
  .scan_strobe(scan_strobe), .scan_out(scan_out)
);

// >>> tb/scan_master.sv
// Main unit model: strobes scans while run is high, counts the answers and keeps the latest one
`timescale 1ns/1ps
module scan_master
  import counter_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire scan_s scan_out,
  output logic scan_strobe,
  output logic [31:0] last_data,
  output int scans
);
  always_ff @(posedge clk) begin
    scan_strobe <= rst_b && run;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scans <= 0;
      last_data <= 32'h0;
    end else if (scan_out.valid) begin
      scans <= scans + 1;
      last_data <= scan_out.data;
    end
  end
endmodule // scan_master

// >>> tb/test_multimode_counter_channel.sv
// Self-checking bench for the multimode counter channel
`timescale 1ns/1ps
module test_multimode_counter_channel;
  import counter_channel_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
  logic main_in = 1'b0, b_in = 1'b0, z_in = 1'b0, sec_in = 1'b0, scan_strobe;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, last_data;
  scan_s scan_out;
  int scans, n, errors = 0, cmp_count = 0;

  always #12.5 clk = ~clk;

  multimode_counter_channel i_multimode_counter_channel (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_in(main_in),
    .phase_b_in(b_in), .index_in(z_in), .second_in(sec_in), .scan_strobe(scan_strobe),
    .scan_out(scan_out)
  );
  scan_master i_scan_master (
    .clk(clk), .rst_b(rst_b), .run(run), .scan_out(scan_out), .scan_strobe(scan_strobe),
    .last_data(last_data), .scans(scans)
  );

  task automatic check(input logic [31:0] got, input int exp, input int tol, input string s);
    cmp_count++;
    if (got !== 32'(exp) && (tol == 0 || (got !== 32'(exp + 1) && got !== 32'(exp - 1)))) begin
      errors++;
      $display("MISMATCH at %0t: %s got %0d expected %0d", $time, s, got, exp);
    end
  endtask

  function automatic logic [31:0] cf(input logic [2:0] m, input logic [9:0] f);
    return {19'h0, f, m};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input int exp, input string s);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, 0, s);
  endtask

  // Waits for a calm input, then k back-to-back scans
  task automatic scan(input int k, input int exp, input int tol, input string s);
    int c;
    repeat (70) @(posedge clk);
    c = scans;
    run <= 1'b1;
    repeat (k) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(scans - c), k, 0, "answers");
    check(last_data, exp, tol, s);
  endtask

  task automatic pulses(input int m, input int hi, input int lo);
    repeat (m) begin
      @(posedge clk);
      main_in <= 1'b1;
      repeat (hi) @(posedge clk);
      main_in <= 1'b0;
      repeat (lo - 1) @(posedge clk);
    end
  endtask

  task automatic tpair(input logic m, input int d);
    @(posedge clk);
    main_in <= m;
    repeat (d) @(posedge clk);
    sec_in <= 1'b1;
    repeat (4) @(posedge clk);
    main_in <= 1'b0;
    sec_in <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h2bda));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(CONFIG_OFFSET, CONFIG_RESET, "cfg reset");
    rd(DEBOUNCE_OFFSET, 0, "deb reset");
    wr(RESULT_OFFSET, $urandom);
    rd(RESULT_OFFSET, 0, "result ro");
    rd(4'h6, 0, "unmapped");
    n = $urandom;
    wr(CONFIG_OFFSET, n);
    rd(CONFIG_OFFSET, n & 32'h1fff, "cfg mask");
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      wr(CONFIG_OFFSET, cf(MODE_CODE_COUNT, {8'h0, i[1], i[0]}));
      n = $urandom_range(20, 1);
      pulses(n, 2, 2);
      scan(1, n, 0, "count");
      scan(2, 0, 0, "cleared");
    end
    wr(DEBOUNCE_OFFSET, 32'h6);
    for (int d = 0; d < 2; d++) begin
      wr(CONFIG_OFFSET, cf(MODE_CODE_COUNT, {7'h0, d[0], 2'b10}));
      pulses(3, 1, 1);
      repeat (12) @(posedge clk);
      pulses(1, 10, 12);
      scan(1, 2 - d, 0, "debounce");
    end
    wr(DEBOUNCE_OFFSET, 32'h0);
    wr(CONFIG_OFFSET, cf(MODE_CODE_TOTALIZE, 10'h2));
    n = $urandom_range(30, 1);
    pulses(n, 2, 2);
    scan(1, n, 0, "total");
    pulses(5, 2, 2);
    scan(1, n + 5, 0, "total kept");
    $display("counting done");
    for (int k = 0; k < 4; k++) begin
      wr(CONFIG_OFFSET, cf(MODE_CODE_PERIOD, {3'h0, k[1:0], k[1:0], 3'h2}));
      pulses(10 ** k + 1, 4, 4);
      scan(2, 10, 1, "period");
    end
    $display("period done");
    wr(CONFIG_OFFSET, cf(MODE_CODE_PULSE, 10'h2));
    pulses(1, 4, 8);
    pulses(1, 12, 8);
    scan(1, 15, 1, "high width");
    wr(CONFIG_OFFSET, cf(MODE_CODE_PULSE, 10'h0));
    pulses(2, 4, 16);
    pulses(1, 4, 8);
    scan(1, 20, 1, "low width");
    $display("pulse width done");
    wr(CONFIG_OFFSET, cf(MODE_CODE_TIMING, 10'h202));
    tpair(1'b1, 8);
    scan(1, 10, 1, "timing");
    tpair(1'b0, 8);
    scan(1, 10, 1, "idle edge");
    tpair(1'b1, 16);
    scan(1, 20, 1, "next interval");
    tpair(1'b1, 53000);
    scan(1, 65535, 0, "saturated");
    $display("timing done");
    for (int r = 0; r < 3; r++) begin
      wr(CONFIG_OFFSET, cf(MODE_CODE_ENCODER, {1'b0, r[1:0], 7'h0}));
      for (int i = 0; i < 20; i++) begin
        @(posedge clk);
        main_in <= (i % 4) < 2;
        b_in <= (i % 4) == 1 || (i % 4) == 2;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd(COUNT_OFFSET, 5 << r, "encoder");
    end
    @(posedge clk);
    z_in <= 1'b1;
    repeat (3) @(posedge clk);
    z_in <= 1'b0;
    repeat (3) @(posedge clk);
    rd(COUNT_OFFSET, 0, "index");
    $display("encoder done");
    give_verdict();
  end
endmodule // test_multimode_counter_channel
